// >>> logic/pcf_map.svh
/*
  Offsets, field positions, reset values and timing counts of the clock fanout control.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register port.
*/
`ifndef PCF_MAP_SVH
`define PCF_MAP_SVH
// Register byte offsets
`define PCF_CTRL_OFFSET 8'h00
`define PCF_FSEL_OFFSET 8'h04
`define PCF_STATUS_OFFSET 8'h08
`define PCF_IRQ_STATUS_OFFSET 8'h0C
`define PCF_IRQ_MASK_OFFSET 8'h10
// Control register fields
`define PCF_CTRL_REF_SEL 0
`define PCF_CTRL_BYPASS 1
`define PCF_CTRL_POLARITY 2
`define PCF_CTRL_STYLE 3
`define PCF_CTRL_PWR_N 4
`define PCF_CTRL_STOP_LSB 5
`define PCF_CTRL_FBF_LSB 10
`define PCF_CTRL_DIV_LSB 12
`define PCF_CTRL_WIDTH 16
// Reset values: polarity high, powered, divider MM, zero-delay feedback
`define PCF_CTRL_RESET 16'h5414
`define PCF_FSEL_RESET 10'h155
// Interrupt status bits
`define PCF_IRQ_LOCK_GAINED 0
`define PCF_IRQ_LOCK_LOST 1
// Timing
`define PCF_CLK_PERIOD_NS 10
`define PCF_REF_TIMEOUT_NS 480
`define PCF_REF_TIMEOUT_CYC ((`PCF_REF_TIMEOUT_NS) / (`PCF_CLK_PERIOD_NS))
`define PCF_LOCK_MATCHES 4
`endif

// >>> logic/pcf_pkg.sv
/*
  Types shared by the clock fanout control modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package pcf_pkg;
  // Output function select codes
  typedef enum logic [1:0] {
    PCF_FN_DIV2 = 2'h0,
    PCF_FN_ZERO = 2'h1,
    PCF_FN_INV = 2'h2,
    PCF_FN_DIV4 = 2'h3
  } pcf_fn_t;
  // Lock tracker states, one-hot
  typedef enum logic [2:0] {
    PCF_LK_IDLE = 3'h1,
    PCF_LK_TRACK = 3'h2,
    PCF_LK_LOCKED = 3'h4
  } pcf_lock_t;
endpackage : pcf_pkg
`default_nettype wire

// >>> logic/pcf_bank_if.sv
/*
  Signals between the control core and one output bank generator.
  Assumes one instance per bank, all on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface pcf_bank_if;
  logic base; // Internal base clock level
  logic base_rise; // Base clock rose last cycle
  logic pd_active; // Power-down in force
  logic style; // Stop style: 1 gate, 0 tri-state
  logic pol; // Edge polarity select
  logic stop_req; // Bank stop request
  logic [1:0] fsel; // Function select
  logic out; // Registered true output
  logic out_n; // Registered complement output
  logic oe_n; // Output enable, low drives
  logic stopped; // Bank parked by its stop request
  modport ctrl (output base, base_rise, pd_active, style, pol, stop_req, fsel,
                input out, out_n, oe_n, stopped);
  modport bank (input base, base_rise, pd_active, style, pol, stop_req, fsel,
                output out, out_n, oe_n, stopped);
endinterface : pcf_bank_if
`default_nettype wire

// >>> logic/pcf_bank.sv
/*
  One output bank: function select, divide, synchronous stop and power-down parking.
  Assumes base clock and its rise pulse come from the control core on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module pcf_bank (
  input wire logic clk,
  input wire logic rst_n,
  pcf_bank_if.bank bif
);
  import pcf_pkg::*;
  logic [1:0] div_cnt; // Divide counter, steps on base rise
  logic stopped; // Stop flag, held through power-down
  logic raw; // Running output before parking
  logic rest; // Parked level of the true output
  logic next_stopped;
  logic parked;
  // Function decode
  assign raw = (pcf_fn_t'(bif.fsel) == PCF_FN_ZERO) ? bif.base :
               (pcf_fn_t'(bif.fsel) == PCF_FN_INV) ? ~bif.base :
               (pcf_fn_t'(bif.fsel) == PCF_FN_DIV2) ? div_cnt[0] : div_cnt[1];
  // Rest opposite to polarity
  assign rest = ~bif.pol;
  // Stop and release only at the rest level, so no runt pulse
  assign next_stopped = bif.pd_active ? stopped :
                        (raw == rest) ? bif.stop_req : stopped;
  assign parked = bif.pd_active | stopped;
  // Divide counter, halted in power-down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 2'h0;
    end else if (bif.base_rise && !bif.pd_active) begin
      div_cnt <= div_cnt + 2'h1;
    end
  end
  // Stop flag and output registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stopped <= 1'b0;
      bif.out <= 1'b0;
      bif.out_n <= 1'b1;
      bif.oe_n <= 1'b0;
    end else begin
      stopped <= next_stopped;
      bif.out <= parked ? rest : raw;
      bif.out_n <= parked ? ~rest : ~raw;
      bif.oe_n <= parked & ~bif.style;
    end
  end
  assign bif.stopped = stopped;
endmodule : pcf_bank
`default_nettype wire

// >>> logic/pcf_top.sv
/*
  Clock fanout control core: reference select, edge alignment, internal oscillator model,
  lock tracking, five output banks plus feedback bank, AXI4-Lite registers and interrupt.
  Assumes reference clocks arrive asynchronously and are much slower than CLK.
*/
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "pcf_map.svh"
module pcf_top #(
  parameter int PERIOD_W = 8,
  parameter int BANKS = 5
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic REF_CLOCK_A,
  input wire logic REF_CLOCK_B,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [2*BANKS-1:0] BANK_CLOCK_OUT,
  output logic [2*BANKS-1:0] BANK_CLOCK_OE_N,
  output logic FEEDBACK_CLOCK_OUT,
  output logic FEEDBACK_CLOCK_OUT_N,
  output logic FEEDBACK_OE_N,
  output logic LOCK,
  output logic IRQ
);
  import pcf_pkg::*;

  // Three-level digit: 0 low, 1 mid, 2 high, 3 read as mid
  function automatic logic [3:0] fb_divider(input logic [3:0] sel);
    logic [1:0] hi;
    logic [1:0] lo;
    hi = (sel[3:2] == 2'h3) ? 2'h1 : sel[3:2];
    lo = (sel[1:0] == 2'h3) ? 2'h1 : sel[1:0];
    case ({hi, lo})
      4'h0: fb_divider = 4'h2;
      4'h1: fb_divider = 4'h3;
      4'h2: fb_divider = 4'h4;
      4'h4: fb_divider = 4'h5;
      4'h5: fb_divider = 4'h1;
      4'h6: fb_divider = 4'h6;
      4'h8: fb_divider = 4'h8;
      4'h9: fb_divider = 4'hA;
      default: fb_divider = 4'hC;
    endcase
  endfunction : fb_divider

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] strb);
    merge_strb = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge_strb[8*i +: 8] = dat[8*i +: 8];
      end
    end
  endfunction : merge_strb

  // Reset release synchroniser
  logic rst_m; // First stage
  logic rst_n; // Released reset
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // Registers
  logic [`PCF_CTRL_WIDTH-1:0] ctrl; // Control bits
  logic [2*BANKS-1:0] fsel; // Bank function selects
  logic [1:0] irq_status; // Sticky events
  logic [1:0] irq_mask; // Interrupt enables
  wire logic ref_select = ctrl[`PCF_CTRL_REF_SEL];
  wire logic bypass = ctrl[`PCF_CTRL_BYPASS];
  wire logic pol = ctrl[`PCF_CTRL_POLARITY];
  wire logic style = ctrl[`PCF_CTRL_STYLE];
  wire logic pwr_on = ctrl[`PCF_CTRL_PWR_N];
  wire logic [BANKS-1:0] stop_req = ctrl[`PCF_CTRL_STOP_LSB +: BANKS];
  wire logic [1:0] fb_fsel = ctrl[`PCF_CTRL_FBF_LSB +: 2];
  wire logic [3:0] div_sel = ctrl[`PCF_CTRL_DIV_LSB +: 4];

  // Reference synchronisers, second stage only is read
  logic ref_a_m;
  logic ref_a_s;
  logic ref_b_m;
  logic ref_b_s;
  logic ref_d; // Selected reference, one cycle late
  wire logic ref_sel = ref_select ? ref_b_s : ref_a_s;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      {ref_a_m, ref_a_s, ref_b_m, ref_b_s, ref_d} <= 5'h00;
    end else begin
      ref_a_m <= REF_CLOCK_A;
      ref_a_s <= ref_a_m;
      ref_b_m <= REF_CLOCK_B;
      ref_b_s <= ref_b_m;
      ref_d <= ref_sel;
    end
  end
  wire logic aligned_ref = pol ? ref_sel : ~ref_sel;
  // Active reference edge, ignored while powered down
  wire logic act_edge = pwr_on & (pol ? (ref_sel & ~ref_d) : (~ref_sel & ref_d));

  // Reference period measurement
  logic [PERIOD_W-1:0] per_cnt; // Cycles since last active edge
  logic [PERIOD_W-1:0] per_last; // Last full period
  logic timed_out; // No edge within timeout
  wire logic at_timeout = (per_cnt >= PERIOD_W'(`PCF_REF_TIMEOUT_CYC));
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt <= '0;
      per_last <= '0;
      timed_out <= 1'b0;
    end else if (!pwr_on) begin
      per_cnt <= '0;
      timed_out <= 1'b1;
    end else if (act_edge) begin
      per_last <= per_cnt + PERIOD_W'(1);
      per_cnt <= '0;
      timed_out <= 1'b0;
    end else if (at_timeout) begin
      timed_out <= 1'b1;
    end else begin
      per_cnt <= per_cnt + PERIOD_W'(1);
    end
  end

  // Oscillator model: period divided by the feedback divider
  wire logic [3:0] fb_div = fb_divider(div_sel);
  wire logic [PERIOD_W-1:0] half_raw = per_last / PERIOD_W'({fb_div, 1'b0});
  wire logic [PERIOD_W-1:0] half = (half_raw == '0) ? PERIOD_W'(1) : half_raw;
  logic [PERIOD_W-1:0] vco_cnt;
  logic vco;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      vco_cnt <= '0;
      vco <= 1'b0;
    end else if (!pwr_on) begin
      vco_cnt <= vco_cnt; // Switching halted
    end else if (act_edge) begin
      vco_cnt <= '0; // Phase realigned to the active edge
      vco <= 1'b1;
    end else if (vco_cnt + PERIOD_W'(1) >= half) begin
      vco_cnt <= '0;
      vco <= ~vco;
    end else begin
      vco_cnt <= vco_cnt + PERIOD_W'(1);
    end
  end

  // Base clock for the banks, bypass takes the reference directly
  wire logic next_base = bypass ? aligned_ref : vco;
  logic base;
  logic base_rise;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      base <= 1'b0;
      base_rise <= 1'b0;
    end else begin
      base <= next_base;
      base_rise <= next_base & ~base;
    end
  end

  // Lock tracker: consecutive matching periods
  pcf_lock_t lk_state;
  pcf_lock_t next_lk_state;
  logic [2:0] match_cnt;
  wire logic [PERIOD_W-1:0] per_now = per_cnt + PERIOD_W'(1);
  wire logic per_match = (per_now <= per_last + PERIOD_W'(1)) && (per_now + PERIOD_W'(1) >= per_last);
  wire logic lose = !pwr_on || bypass || timed_out || (act_edge && !per_match);
  always_comb begin
    next_lk_state = lk_state;
    unique case (lk_state)
      PCF_LK_IDLE: begin
        if (act_edge && !lose) begin
          next_lk_state = PCF_LK_TRACK;
        end
      end
      PCF_LK_TRACK: begin
        if (lose) begin
          next_lk_state = PCF_LK_IDLE;
        end else if (act_edge && match_cnt == 3'(`PCF_LOCK_MATCHES - 1)) begin
          next_lk_state = PCF_LK_LOCKED;
        end
      end
      PCF_LK_LOCKED: begin
        if (lose) begin
          next_lk_state = PCF_LK_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      lk_state <= PCF_LK_IDLE;
      match_cnt <= 3'h0;
      LOCK <= 1'b0;
    end else begin
      lk_state <= next_lk_state;
      match_cnt <= (next_lk_state != PCF_LK_TRACK) ? 3'h0 : match_cnt + 3'(act_edge);
      LOCK <= (next_lk_state == PCF_LK_LOCKED);
    end
  end
  wire logic lock_gained = (next_lk_state == PCF_LK_LOCKED) && !LOCK;
  wire logic lock_lost = (next_lk_state != PCF_LK_LOCKED) && LOCK;

  // Bank generators, the last one drives feedback
  pcf_bank_if bif [BANKS:0] ();
  logic [BANKS:0] stopped;
  for (genvar b = 0; b <= BANKS; b++) begin : g_bank
    assign bif[b].base = base;
    assign bif[b].base_rise = base_rise;
    assign bif[b].pd_active = ~pwr_on;
    assign bif[b].style = style;
    assign bif[b].pol = pol;
    assign bif[b].stop_req = (b < BANKS) ? stop_req[b % BANKS] : 1'b0;
    assign bif[b].fsel = (b < BANKS) ? fsel[2*(b % BANKS) +: 2] : fb_fsel;
    assign stopped[b] = bif[b].stopped;
    pcf_bank u_bank (
      .clk(CLK),
      .rst_n(rst_n),
      .bif(bif[b])
    );
    if (b < BANKS) begin : g_out
      assign BANK_CLOCK_OUT[2*b +: 2] = {2{bif[b].out}};
      assign BANK_CLOCK_OE_N[2*b +: 2] = {2{bif[b].oe_n}};
    end else begin : g_fb
      assign FEEDBACK_CLOCK_OUT = bif[b].out;
      assign FEEDBACK_CLOCK_OUT_N = bif[b].out_n;
      assign FEEDBACK_OE_N = bif[b].oe_n;
    end
  end

  // AXI4-Lite write path
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire logic do_write = aw_held & w_held & ~S_AXI_BVALID;
  wire logic wr_ctrl = do_write && aw_addr == `PCF_CTRL_OFFSET;
  wire logic wr_fsel = do_write && aw_addr == `PCF_FSEL_OFFSET;
  wire logic wr_stat = do_write && aw_addr == `PCF_IRQ_STATUS_OFFSET;
  wire logic wr_mask = do_write && aw_addr == `PCF_IRQ_MASK_OFFSET;
  wire logic wr_ok = wr_ctrl | wr_fsel | wr_stat | wr_mask | (aw_addr == `PCF_STATUS_OFFSET);
  wire logic [31:0] wmerge_ctrl = merge_strb(32'(ctrl), w_data, w_strb);
  wire logic [31:0] wmerge_fsel = merge_strb(32'(fsel), w_data, w_strb);
  wire logic [31:0] wmerge_mask = merge_strb(32'(irq_mask), w_data, w_strb);
  wire logic [31:0] wclear = merge_strb(32'h0, w_data, w_strb);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      {aw_held, w_held, S_AXI_BVALID} <= 3'h0;
      {S_AXI_AWREADY, S_AXI_WREADY} <= 2'h0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      S_AXI_BRESP <= 2'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= {S_AXI_AWADDR[7:2], 2'h0};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      S_AXI_AWREADY <= ~aw_held & ~(S_AXI_AWVALID & S_AXI_AWREADY) & ~S_AXI_BVALID;
      S_AXI_WREADY <= ~w_held & ~(S_AXI_WVALID & S_AXI_WREADY) & ~S_AXI_BVALID;
      if (do_write) begin
        {aw_held, w_held} <= 2'h0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? 2'h0 : 2'h2; // Unmapped gives SLVERR
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Register updates; hardware set wins over write-one clear
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `PCF_CTRL_RESET;
      fsel <= `PCF_FSEL_RESET;
      irq_mask <= 2'h0;
      irq_status <= 2'h0;
      IRQ <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl <= wmerge_ctrl[`PCF_CTRL_WIDTH-1:0];
      if (wr_fsel) fsel <= wmerge_fsel[2*BANKS-1:0];
      if (wr_mask) irq_mask <= wmerge_mask[1:0];
      irq_status <= (irq_status & ~(wr_stat ? wclear[1:0] : 2'h0)) | {lock_lost, lock_gained};
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // AXI4-Lite read path, answer one cycle after address
  wire logic [7:0] ar_addr = {S_AXI_ARADDR[7:2], 2'h0};
  wire logic [31:0] status_word = 32'({stopped, ref_select, LOCK});
  wire logic rd_ok = ar_addr == `PCF_CTRL_OFFSET || ar_addr == `PCF_FSEL_OFFSET ||
                     ar_addr == `PCF_STATUS_OFFSET || ar_addr == `PCF_IRQ_STATUS_OFFSET ||
                     ar_addr == `PCF_IRQ_MASK_OFFSET;
  wire logic [31:0] rd_mux = (ar_addr == `PCF_CTRL_OFFSET) ? 32'(ctrl) :
                             (ar_addr == `PCF_FSEL_OFFSET) ? 32'(fsel) :
                             (ar_addr == `PCF_STATUS_OFFSET) ? status_word :
                             (ar_addr == `PCF_IRQ_STATUS_OFFSET) ? 32'(irq_status) :
                             (ar_addr == `PCF_IRQ_MASK_OFFSET) ? 32'(irq_mask) : 32'h0;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= 2'h0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_mux;
      S_AXI_RRESP <= rd_ok ? 2'h0 : 2'h2;
    end else if (S_AXI_RVALID) begin
      S_AXI_RVALID <= ~S_AXI_RREADY;
    end else begin
      S_AXI_ARREADY <= 1'b1;
    end
  end
endmodule : pcf_top
`default_nettype wire

// >>> bench/pcf_checker.sv
/*
  Port checker for the clock fanout control: bus answers and parked output levels.
  Assumes whole-word writes and a master that holds BREADY high while waiting.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pcf_map.svh"
module pcf_checker #(
  parameter int BANKS = 5
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [2*BANKS-1:0] BANK_CLOCK_OUT,
  input wire logic [2*BANKS-1:0] BANK_CLOCK_OE_N,
  input wire logic FEEDBACK_CLOCK_OUT,
  input wire logic FEEDBACK_CLOCK_OUT_N,
  input wire logic FEEDBACK_OE_N,
  input wire logic LOCK
);
  logic [7:0] wa; // Captured write address
  logic [31:0] wd; // Captured write data
  logic [15:0] ctl; // Shadow of the control register
  logic [6:0] age; // Cycles since the last control write
  logic pair_ok; // Both outputs of every bank agree
  wire settled = (age == 7'h7F) && !S_AXI_AWVALID && !S_AXI_WVALID && !S_AXI_BVALID;
  wire pol = ctl[2];
  wire sty = ctl[3];
  wire pwr = ctl[4];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Shadow follows completed control writes
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wa <= 8'h00;
      wd <= 32'h0;
      ctl <= `PCF_CTRL_RESET;
      age <= 7'h00;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) wa <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY) wd <= S_AXI_WDATA;
      if (S_AXI_BVALID && S_AXI_BREADY && wa == 8'h00) begin
        ctl <= wd[15:0];
        age <= 7'h00;
      end else if (age != 7'h7F) begin
        age <= age + 7'h01;
      end
    end
  end
  // Pair comparison across banks
  always_comb begin
    pair_ok = 1'b1;
    for (int b = 0; b < BANKS; b++) begin
      if (BANK_CLOCK_OUT[2*b] != BANK_CLOCK_OUT[2*b+1]) pair_ok = 1'b0;
    end
  end
  a_pair_equal: assert property (pair_ok) else $error("bank outputs differ");
  a_pd_no_lock: assert property (settled && !pwr |-> !LOCK) else $error("lock in power-down");
  a_bypass_no_lock: assert property (settled && ctl[1] |-> !LOCK) else $error("lock in bypass");
  a_pd_tristate: assert property (settled && !pwr && !sty |-> &{BANK_CLOCK_OE_N, FEEDBACK_OE_N})
    else $error("power-down outputs driven");
  a_pd_gated_rest: assert property (settled && !pwr && sty |-> BANK_CLOCK_OUT == {2*BANKS{!pol}}
    && FEEDBACK_CLOCK_OUT == !pol && FEEDBACK_CLOCK_OUT_N == pol && !FEEDBACK_OE_N) else $error("bad rest level");
  a_pd_frozen: assert property (settled && !pwr |=> $stable(BANK_CLOCK_OUT) && $stable(FEEDBACK_CLOCK_OUT))
    else $error("switching in power-down");
  a_normal_driven: assert property (settled && pwr && ctl[9:5] == 5'h00 |-> BANK_CLOCK_OE_N == '0)
    else $error("running bank not driven");
  a_stop_parked: assert property (settled && pwr && ctl[5] && sty |-> BANK_CLOCK_OUT[1:0] == {2{!pol}})
    else $error("stopped bank not parked");
  a_stop_tristate: assert property (settled && pwr && ctl[5] && !sty |-> BANK_CLOCK_OE_N[1:0] == 2'h3)
    else $error("stopped bank driven");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read late");
  a_read_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
endmodule : pcf_checker
bind pcf_top pcf_checker #(.BANKS(BANKS)) chk (.*);
`default_nettype wire

// >>> bench/pcf_ref_board.sv
/*
  Board model: two reference clocks of 125 ns, unrelated in phase.
  Assumes the bench enables each clock; a disabled clock stands low.
*/
`timescale 1ns/10ps
`default_nettype none
module pcf_ref_board (
  input wire logic en_a,
  input wire logic en_b,
  output logic ref_clock_a,
  output logic ref_clock_b
);
  // Reference A from time zero
  initial begin
    ref_clock_a = 1'b0;
    forever #62.5 ref_clock_a = en_a ? ~ref_clock_a : 1'b0;
  end
  // Reference B offset in phase
  initial begin
    ref_clock_b = 1'b0;
    #21.3;
    forever #62.5 ref_clock_b = en_b ? ~ref_clock_b : 1'b0;
  end
endmodule : pcf_ref_board
`default_nettype wire

// >>> bench/test_pll_clock_fanout_control.sv
/*
  Testbench of the clock fanout control: register traffic, lock, stop and power-down.
  Assumes the checker is bound into the design and the board model drives the references.
*/
`timescale 1ns/10ps
`default_nettype none
module test_pll_clock_fanout_control;
  typedef struct {string nm; logic [33:0] ex; logic [33:0] mk;} pcf_note_t;
  logic CLK, RSTN, REF_CLOCK_A, REF_CLOCK_B, LOCK, IRQ;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic FEEDBACK_CLOCK_OUT, FEEDBACK_CLOCK_OUT_N, FEEDBACK_OE_N;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [9:0] BANK_CLOCK_OUT, BANK_CLOCK_OE_N;
  logic en_a, en_b, probe, p, y;
  logic [31:0] rs, v;
  logic [33:0] e, m;
  int mismatches, checked, cyc;
  pcf_note_t q[$]; // Expected results in order
  wire [33:0] pins = {9'h0, IRQ, LOCK, FEEDBACK_OE_N, FEEDBACK_CLOCK_OUT, FEEDBACK_CLOCK_OUT_N,
                      BANK_CLOCK_OE_N, BANK_CLOCK_OUT};
  pcf_top dut (.*);
  pcf_ref_board board (.en_a(en_a), .en_b(en_b), .ref_clock_a(REF_CLOCK_A), .ref_clock_b(REF_CLOCK_B));
  // System clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Xorshift source
  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  // Control word: select, bypass, polarity, style, powered, stops
  function logic [31:0] ctl(input logic s, b, pl, st, w, input logic [4:0] sp);
    return {16'h0, 4'h5, 2'h1, sp, w, st, pl, b, s};
  endfunction : ctl
  task print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // Oldest note against an appearing result
  task take(input logic [33:0] r);
    pcf_note_t n;
    if (q.size() == 0) begin
      mismatches++;
      $display("[FAIL] unexpected result expected none seen %h", r);
    end else begin
      n = q.pop_front();
      checked++;
      if (((r ^ n.ex) & n.mk) !== 34'h0) begin
        mismatches++;
        $display("[FAIL] %s expected %h seen %h", n.nm, n.ex & n.mk, r & n.mk);
      end
    end
  endtask : take
  // Result watcher
  always @(posedge CLK) begin
    if (S_AXI_RVALID && S_AXI_RREADY) take({S_AXI_RRESP, S_AXI_RDATA});
    if (S_AXI_BVALID && S_AXI_BREADY) take({32'h0, S_AXI_BRESP});
    if (probe) take(pins);
  end
  // Hang limit
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q.push_back('{"write response", {32'h0, r}, 34'h3});
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
    @(posedge CLK);
  endtask : wr
  task rd(input logic [7:0] a, input logic [33:0] ex, mk, input string nm);
    q.push_back('{nm, ex, mk});
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
    @(posedge CLK);
  endtask : rd
  task pin(input logic [33:0] ex, mk, input string nm);
    q.push_back('{nm, ex, mk});
    probe <= 1'b1;
    @(posedge CLK);
    probe <= 1'b0;
    @(posedge CLK);
  endtask : pin
  // Main sequence
  initial begin
    rs = 32'd70;
    {RSTN, en_a, en_b, probe, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    S_AXI_WSTRB = 4'hF;
    repeat (10) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (4) @(posedge CLK);
    rd(8'h00, {2'h0, 32'h5414}, {2'h3, 32'hFFFF}, "ctrl reset");
    rd(8'h04, {2'h0, 32'h155}, {2'h3, 32'h3FF}, "fsel reset");
    rd(8'h14, {2'h2, 32'h0}, '1, "unmapped read");
    wr(8'h14, 32'h0, 2'h2);
    wr(8'h08, 32'h0, 2'h0);
    $display("test registers done");
    en_a <= 1'b1;
    en_b <= 1'b1;
    do @(posedge CLK); while (!LOCK);
    rd(8'h08, {2'h0, 32'h1}, {2'h3, 32'h3}, "status lock a");
    rd(8'h0C, 34'h1, 34'h1, "lock gained flag");
    wr(8'h10, 32'h1, 2'h0);
    pin(34'h1 << 24, 34'h1 << 24, "irq raised");
    wr(8'h0C, 32'h1, 2'h0);
    pin(34'h0, 34'h1 << 24, "irq cleared");
    wr(8'h00, ctl(1, 0, 1, 0, 1, 0), 2'h0);
    en_a <= 1'b0;
    repeat (60) @(posedge CLK);
    do @(posedge CLK); while (!LOCK);
    rd(8'h08, {2'h0, 32'h3}, {2'h3, 32'h3}, "status lock b");
    wr(8'h00, ctl(1, 1, 1, 0, 1, 0), 2'h0);
    repeat (150) @(posedge CLK);
    pin(34'h0, 34'h1 << 23, "lock in bypass");
    $display("test lock done");
    for (int i = 0; i < 4; i++) begin
      p = i[0];
      y = i[1];
      wr(8'h00, ctl(1, 0, p, y, 1, 5'h01), 2'h0);
      repeat (150) @(posedge CLK);
      e = {22'h0, {2{~y}}, 8'h0, {2{~p}}};
      pin(e, 34'hFFC00 | {32'h0, y, y}, "bank stop");
      rd(8'h08, {2'h0, 32'h4}, {2'h3, 32'h4}, "stopped flag");
      wr(8'h00, ctl(1, 0, p, y, 0, 0), 2'h0);
      repeat (150) @(posedge CLK);
      e = {11'h0, ~y, ~p, p, {10{~y}}, {10{~p}}};
      m = {11'h1, 1'b1, y, y, 10'h3FF, {10{y}}};
      pin(e, m, "power down");
      wr(8'h00, ctl(1, 0, p, y, 1, 0), 2'h0);
      repeat (150) @(posedge CLK);
      pin(34'h0, 34'hFFC00 | (34'h1 << 22), "resume driven");
    end
    $display("test stop and power down done");
    for (int k = 0; k < 4; k++) begin
      v = (rnd() & 32'h3FC) | k;
      wr(8'h04, v, 2'h0);
      rd(8'h04, {2'h0, 22'h0, v[9:0]}, {2'h3, 32'h3FF}, "fsel");
    end
    $display("test function select done");
    print_verdict();
  end
endmodule : test_pll_clock_fanout_control
`default_nettype wire
